// *** hw/mfd_defs.vh ***
// Constants for the field move engine (indirect with displacement to postinc).
`ifndef MFD_DEFS_VH
`define MFD_DEFS_VH
// Wishbone word offsets, byte address bits [4:2].
`define MFD_OFS_CTRL 3'h0
`define MFD_OFS_OPC 3'h1
`define MFD_OFS_EXT 3'h2
`define MFD_OFS_FIELD 3'h3
`define MFD_OFS_FLAGS 3'h4
`define MFD_OFS_RIDX 3'h5
`define MFD_OFS_RDATA 3'h6
// Control and status bits.
`define MFD_CTRL_START 0
`define MFD_CTRL_BUSY 0
`define MFD_CTRL_DONE 1
`define MFD_CTRL_BADOP 2
// Opcode word layout.
`define MFD_OPC_HI 15
`define MFD_OPC_LO 10
`define MFD_OPC_VAL 6'h34
`define MFD_OPC_F 9
`define MFD_OPC_SRC_HI 8
`define MFD_OPC_SRC_LO 5
`define MFD_OPC_R 4
`define MFD_OPC_RD_HI 3
`define MFD_OPC_RD_LO 0
// Field register layout: preset a in [4:0], preset b in [12:8], 0 means 32.
`define MFD_FLD_A_HI 4
`define MFD_FLD_A_LO 0
`define MFD_FLD_B_HI 12
`define MFD_FLD_B_LO 8
`define MFD_FIELD_RST 16'h0000
`define MFD_FLAGS_RST 4'h0
`define MFD_FULL_SIZE 6'h20
`endif

// *** hw/mfd_move_field.v ***
// Field move engine: memory to memory move with postincremented destination.
`timescale 1ns/1ns
`default_nettype none
`include "mfd_defs.vh"
module mfd_move_field (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:2] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Local memory port, 32-bit words, bit address [31:5] selects word
    output reg [26:0] mem_adr_o,
    output reg mem_rd_o,
    output reg mem_wr_o,
    output reg [31:0] mem_wdat_o,
    output reg [31:0] mem_wmask_o,
    input wire [31:0] mem_rdat_i,
    input wire mem_ack_i
);
    localparam ST_IDLE = 3'h0;
    localparam ST_RD0 = 3'h1;
    localparam ST_RD1 = 3'h2;
    localparam ST_WR0 = 3'h3;
    localparam ST_WR1 = 3'h4;
    localparam ST_UPD = 3'h5;

    // Mask of the low size bits; size is 1 to 32.
    function [31:0] fmask;
        input [5:0] size;
        begin
            if (size == `MFD_FULL_SIZE)
                fmask = 32'hFFFFFFFF;
            else
                fmask = ~(32'hFFFFFFFF << size[4:0]);
        end
    endfunction

    // A preset of zero encodes the full 32-bit field.
    function [5:0] psize;
        input [4:0] code;
        begin
            psize = (code == 5'h00) ? `MFD_FULL_SIZE : {1'b0, code};
        end
    endfunction

    reg [31:0] rf [0:31];
    reg [2:0] state_reg;
    reg [15:0] opc_reg;
    reg [15:0] ext_reg;
    reg [15:0] field_reg;
    reg [3:0] flags_reg;
    reg [4:0] ridx_reg;
    reg done_reg;
    reg badop_reg;
    reg [31:0] src_reg;
    reg [31:0] dst_reg;
    reg [4:0] rd_idx_reg;
    reg [5:0] size_reg;
    reg [31:0] lo_reg;
    reg [63:0] wdat_reg;
    reg [63:0] wmask_reg;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire busy = (state_reg != ST_IDLE);
    wire start = wb_wr && wb_adr_i == `MFD_OFS_CTRL && wb_sel_i[0] &&
        wb_dat_i[`MFD_CTRL_START] && !busy;
    wire opc_ok = opc_reg[`MFD_OPC_HI:`MFD_OPC_LO] == `MFD_OPC_VAL;
    wire [4:0] src_idx = {opc_reg[`MFD_OPC_R],
        opc_reg[`MFD_OPC_SRC_HI:`MFD_OPC_SRC_LO]};
    wire [4:0] rd_idx = {opc_reg[`MFD_OPC_R],
        opc_reg[`MFD_OPC_RD_HI:`MFD_OPC_RD_LO]};
    // Preset chosen by the select bit, held in the set-field register.
    wire [5:0] sel_size = opc_reg[`MFD_OPC_F] ?
        psize(field_reg[`MFD_FLD_B_HI:`MFD_FLD_B_LO]) :
        psize(field_reg[`MFD_FLD_A_HI:`MFD_FLD_A_LO]);
    wire [31:0] src_addr = rf[src_idx] + {{16{ext_reg[15]}}, ext_reg};
    // Source field may straddle two words, so both are fetched and joined.
    wire [63:0] joined = {mem_rdat_i, lo_reg} >> src_reg[4:0];
    wire [31:0] field = joined[31:0] & fmask(size_reg);
    wire [63:0] place = {32'h00000000, field} << dst_reg[4:0];
    wire [63:0] pmask = {32'h00000000, fmask(size_reg)} << dst_reg[4:0];
    wire [31:0] sum = dst_reg + {26'h0000000, size_reg};

    // Bus slave: one wait state, ack dropped the cycle after it is given.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    `MFD_OFS_CTRL: wb_dat_o <= {29'h00000000, badop_reg,
                        done_reg, busy};
                    `MFD_OFS_OPC: wb_dat_o <= {16'h0000, opc_reg};
                    `MFD_OFS_EXT: wb_dat_o <= {16'h0000, ext_reg};
                    `MFD_OFS_FIELD: wb_dat_o <= {16'h0000, field_reg};
                    `MFD_OFS_FLAGS: wb_dat_o <= {28'h0000000, flags_reg};
                    `MFD_OFS_RIDX: wb_dat_o <= {27'h0000000, ridx_reg};
                    `MFD_OFS_RDATA: wb_dat_o <= rf[ridx_reg];
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Software-loaded registers; writes that would disturb a move in flight
    // are ignored while busy so the operands cannot change mid-transfer.
    always @(posedge clk_i) begin
        if (rst_i) begin
            opc_reg <= 16'h0000;
            ext_reg <= 16'h0000;
            field_reg <= `MFD_FIELD_RST;
            flags_reg <= `MFD_FLAGS_RST;
            ridx_reg <= 5'h00;
        end else if (wb_wr && !busy) begin
            case (wb_adr_i)
                `MFD_OFS_OPC: opc_reg <= wb_dat_i[15:0];
                `MFD_OFS_EXT: ext_reg <= wb_dat_i[15:0];
                `MFD_OFS_FIELD: field_reg <= wb_dat_i[15:0];
                `MFD_OFS_FLAGS: flags_reg <= wb_dat_i[3:0];
                `MFD_OFS_RIDX: ridx_reg <= wb_dat_i[4:0];
                default: ridx_reg <= ridx_reg;
            endcase
        end
        // Flags have no hardware writer: the move never touches them.
    end

    // Register file: software port when idle, postincrement at the end.
    always @(posedge clk_i) begin
        if (state_reg == ST_UPD)
            rf[rd_idx_reg] <= sum;
        else if (wb_wr && !busy && wb_adr_i == `MFD_OFS_RDATA)
            rf[ridx_reg] <= wb_dat_i;
    end

    // Move sequencer.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b0;
            badop_reg <= 1'b0;
            src_reg <= 32'h00000000;
            dst_reg <= 32'h00000000;
            rd_idx_reg <= 5'h00;
            size_reg <= 6'h01;
            lo_reg <= 32'h00000000;
            wdat_reg <= 64'h0;
            wmask_reg <= 64'h0;
            mem_adr_o <= 27'h0000000;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_wdat_o <= 32'h00000000;
            mem_wmask_o <= 32'h00000000;
        end else begin
            // Software clears done by writing one; a completion wins.
            if (wb_wr && !start && wb_adr_i == `MFD_OFS_CTRL &&
                    wb_sel_i[0] && wb_dat_i[`MFD_CTRL_DONE])
                done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start && !opc_ok) begin
                        badop_reg <= 1'b1;
                        done_reg <= 1'b0;
                    end else if (start) begin
                        badop_reg <= 1'b0;
                        done_reg <= 1'b0;
                        src_reg <= src_addr;
                        dst_reg <= rf[rd_idx];
                        rd_idx_reg <= rd_idx;
                        size_reg <= sel_size;
                        mem_adr_o <= src_addr[31:5];
                        mem_rd_o <= 1'b1;
                        state_reg <= ST_RD0;
                    end
                end
                ST_RD0: begin
                    if (mem_ack_i) begin
                        lo_reg <= mem_rdat_i;
                        mem_adr_o <= src_reg[31:5] + 27'h0000001;
                        state_reg <= ST_RD1;
                    end
                end
                ST_RD1: begin
                    if (mem_ack_i) begin
                        // Source is only read, never written back.
                        wdat_reg <= place;
                        wmask_reg <= pmask;
                        mem_rd_o <= 1'b0;
                        mem_wr_o <= 1'b1;
                        mem_adr_o <= dst_reg[31:5];
                        mem_wdat_o <= place[31:0];
                        mem_wmask_o <= pmask[31:0];
                        state_reg <= ST_WR0;
                    end
                end
                ST_WR0: begin
                    if (mem_ack_i && wmask_reg[63:32] != 32'h00000000) begin
                        mem_adr_o <= dst_reg[31:5] + 27'h0000001;
                        mem_wdat_o <= wdat_reg[63:32];
                        mem_wmask_o <= wmask_reg[63:32];
                        state_reg <= ST_WR1;
                    end else if (mem_ack_i) begin
                        mem_wr_o <= 1'b0;
                        state_reg <= ST_UPD;
                    end
                end
                ST_WR1: begin
                    if (mem_ack_i) begin
                        mem_wr_o <= 1'b0;
                        state_reg <= ST_UPD;
                    end
                end
                ST_UPD: begin
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** verif/mfd_checker.sv ***
// Port assertions for the field move engine.
`timescale 1ns/1ns
`default_nettype none
module mfd_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Memory
    input wire logic [26:0] mem_adr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [31:0] mem_wdat_o,
    input wire logic [31:0] mem_wmask_o,
    input wire logic [31:0] mem_rdat_i,
    input wire logic mem_ack_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("ack missing");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack unasked");
    rd_hold_a: assert property (mem_rd_o && !mem_ack_i |=>
        mem_rd_o && $stable(mem_adr_o)) else $error("read dropped");
    wr_hold_a: assert property (mem_wr_o && !mem_ack_i |=>
        mem_wr_o && $stable({mem_adr_o, mem_wdat_o, mem_wmask_o}))
        else $error("write dropped");
    next_word_a: assert property ($rose(mem_rd_o) ##1 mem_ack_i |=>
        mem_rd_o && mem_adr_o == $past(mem_adr_o) + 27'h1)
        else $error("second read");
    wr_after_rd_a: assert property ($fell(mem_rd_o) |-> mem_wr_o)
        else $error("no write");
    wr_mask_a: assert property (mem_wr_o |-> mem_wmask_o != 32'h0)
        else $error("empty mask");
    cover property (mem_wr_o && mem_ack_i ##1 mem_wr_o);
    cover property (mem_rd_o && !mem_ack_i ##1 mem_rd_o);
    cover property (wb_ack_o && !wb_we_i);
endmodule
`default_nettype wire

// *** verif/mfd_mem_model.sv ***
// Bit-masked local memory answering after a chosen number of cycles.
`timescale 1ns/1ns
`default_nettype none
module mfd_mem_model (
    // Clock and lag
    input wire logic clk_i,
    input wire logic [1:0] lag_i,
    // Memory port
    input wire logic [26:0] mem_adr_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [31:0] mem_wdat_i,
    input wire logic [31:0] mem_wmask_i,
    output logic [31:0] mem_rdat_o,
    output logic mem_ack_o
);
    logic [31:0] mem [0:63];
    logic [1:0] cnt = 2'h0;
    logic [31:0] word;
    initial mem_ack_o = 1'b0;
    assign word = mem[mem_adr_i[5:0]];
    // Outside an answer the bus shows the inverse so stale data is caught.
    assign mem_rdat_o = mem_ack_o ? word : ~word;
    always @(posedge clk_i) begin
        mem_ack_o <= 1'b0;
        if ((mem_rd_i || mem_wr_i) && !mem_ack_o) begin
            cnt <= cnt + 2'h1;
            if (cnt == lag_i) begin
                cnt <= 2'h0;
                mem_ack_o <= 1'b1;
                if (mem_wr_i)
                    mem[mem_adr_i[5:0]] <= (word & ~mem_wmask_i) |
                        (mem_wdat_i & mem_wmask_i);
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/mfd_move_field_tb.sv ***
// Self-checking bench for the field move engine.
`timescale 1ns/1ns
`default_nettype none
`include "mfd_defs.vh"
module mfd_move_field_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, wb_ack_o, mem_rd_o, mem_wr_o, mem_ack_i;
    logic [4:2] wb_adr_i = 3'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_wdat_o, mem_wmask_o;
    logic [31:0] mem_rdat_i, rdata;
    logic [26:0] mem_adr_o;
    logic [1:0] lag = 2'h0;
    logic [2047:0] img;
    int bad_count = 0;
    int comparisons = 0;
    mfd_move_field u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .mem_adr_o(mem_adr_o),
        .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o),
        .mem_wdat_o(mem_wdat_o),
        .mem_wmask_o(mem_wmask_o),
        .mem_rdat_i(mem_rdat_i),
        .mem_ack_i(mem_ack_i)
    );
    mfd_mem_model u_mem (.clk_i(clk_i), .lag_i(lag), .mem_adr_i(mem_adr_o),
        .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_wdat_i(mem_wdat_o),
        .mem_wmask_i(mem_wmask_o), .mem_rdat_o(mem_rdat_i),
        .mem_ack_o(mem_ack_i));
    task automatic finish_test;
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(logic we, logic [2:0] adr, logic [31:0] d);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        {wb_adr_i, wb_dat_i} <= {adr, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        rdata = wb_dat_o;
        chk("bus answer", 32'h0, 32'(n / 20));
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic move(logic f, logic [15:0] fld, logic [15:0] disp,
        logic [31:0] sb, logic [31:0] db, logic [5:0] size, logic [1:0] l);
        logic [2047:0] ex;
        logic [10:0] s;
        int n;
        lag <= l;
        bus(1'b1, `MFD_OFS_RIDX, 32'h3);
        bus(1'b1, `MFD_OFS_RDATA, sb);
        bus(1'b1, `MFD_OFS_RIDX, 32'h5);
        bus(1'b1, `MFD_OFS_RDATA, db);
        bus(1'b1, `MFD_OFS_FIELD, {16'h0, fld});
        bus(1'b1, `MFD_OFS_EXT, {16'h0, disp});
        bus(1'b1, `MFD_OFS_FLAGS, 32'hA);
        bus(1'b1, `MFD_OFS_OPC,
            {16'h0, `MFD_OPC_VAL, f, 4'h3, 1'b0, 4'h5});
        bus(1'b1, `MFD_OFS_CTRL, 32'h1);
        n = 0;
        rdata = 32'h0;
        while (rdata[1] !== 1'b1 && n < 60) begin
            bus(1'b0, `MFD_OFS_CTRL, 32'h0);
            n++;
        end
        chk("status", 32'h2, {29'h0, rdata[2:0]});
        s = 11'(sb + {{16{disp[15]}}, disp});
        ex = img;
        for (int i = 0; i < size; i++)
            ex[db[10:0] + 11'(i)] = img[s + 11'(i)];
        for (int w = 0; w < 64; w++)
            chk("word", ex[w*32+:32], u_mem.mem[w]);
        img = ex;
        bus(1'b1, `MFD_OFS_RIDX, 32'h5);
        bus(1'b0, `MFD_OFS_RDATA, 32'h0);
        chk("dest reg", db + 32'(size), rdata);
        bus(1'b0, `MFD_OFS_FLAGS, 32'h0);
        chk("flags", 32'hA, rdata);
        bus(1'b1, `MFD_OFS_CTRL, 32'h2);
        bus(1'b0, `MFD_OFS_CTRL, 32'h0);
        chk("done clear", 32'h0, rdata);
    endtask
    // A start with a foreign opcode must flag it and leave memory alone.
    task automatic bad_start;
        bus(1'b1, `MFD_OFS_OPC, 32'h0000FFFF);
        bus(1'b1, `MFD_OFS_CTRL, 32'h1);
        bus(1'b0, `MFD_OFS_CTRL, 32'h0);
        chk("bad status", 32'h4, rdata);
        for (int w = 0; w < 64; w++)
            chk("kept", img[w*32+:32], u_mem.mem[w]);
    endtask
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        bad_count++;
        finish_test();
    end
    initial begin
        for (int w = 0; w < 64; w++) begin
            img[w*32 +: 32] = 32'h9E37_79B9 * (w + 1);
            u_mem.mem[w] = img[w*32 +: 32];
        end
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        move(1'b0, 16'h0001, 16'h0005, 32'h64, 32'h12C, 6'h01, 2'h0);
        move(1'b1, 16'h0003, 16'hFFF0, 32'h2BC, 32'h3E8, 6'h20, 2'h2);
        move(1'b0, 16'h0A11, 16'h7FFF, 32'h1, 32'h7F0, 6'h11, 2'h1);
        move(1'b1, 16'h0A11, 16'h0000, 32'h40, 32'h5, 6'h0A, 2'h3);
        bad_start();
        bus(1'b0, 3'h7, 32'h0);
        chk("unmapped", 32'h0, rdata);
        finish_test();
    end
endmodule
bind mfd_move_field mfd_checker u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .mem_adr_o(mem_adr_o),
    .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o),
    .mem_wdat_o(mem_wdat_o),
    .mem_wmask_o(mem_wmask_o),
    .mem_rdat_i(mem_rdat_i),
    .mem_ack_i(mem_ack_i)
);
`default_nettype wire
